// >>> hdl/frame_trk_pkg.sv
// package: constants, enums and carrier structs for the paging frame tracker
// assumes one 25 MHz clock; symbols arrive as 2-bit values with a strobe
package frame_trk_pkg;

   // ****************************************************************
   // timing
   // ****************************************************************
   localparam int unsigned CLK_HZ         = 25000000;
   localparam int unsigned FRAME_MS       = 1875;  // 1.875 s
   localparam int unsigned BLOCK_MS       = 160;
   localparam int unsigned FRAME_CYC      = CLK_HZ / 1000 * FRAME_MS;
   localparam int unsigned BLOCK_CYC      = CLK_HZ / 1000 * BLOCK_MS;
   localparam int unsigned MINUTE_S       = 60;
   localparam int unsigned MINUTE_CYC     = CLK_HZ * MINUTE_S;
   localparam int unsigned CLKOUT_HZ      = 38400;
   localparam int unsigned CLKOUT_HALF    = CLK_HZ / (2 * CLKOUT_HZ);
   localparam int unsigned WARM_STEP_CYC  = 1000;

   // ****************************************************************
   // structure
   // ****************************************************************
   localparam int unsigned FRAMES_PER_CYCLE = 128;
   localparam int unsigned BLOCKS_PER_FRAME = 11;
   localparam int unsigned WORDS_PER_BLOCK  = 8;
   localparam int unsigned WORDS_PER_PHASE  = 88;
   localparam int unsigned NUM_PHASES       = 4;
   localparam int unsigned FRAME_NUM_W      = 7;
   localparam int unsigned CYCLE_NUM_W      = 4;
   localparam int unsigned FIW_W            = 11;
   localparam int unsigned CYCLE_NUM_MAX    = 14;
   localparam int unsigned WORD_W           = 32;
   localparam int unsigned DATA_W           = 21;
   localparam int unsigned SYNC_W           = 32;
   localparam int unsigned RX_CTL_W         = 8;
   localparam int unsigned SYM_W            = 2;

   localparam logic [SYNC_W-1:0] SYNC1_PAT = 32'hA6C6AAAA; // arbitrary pattern
   localparam logic [15:0] SYNC2_1600 = 16'h870C;          // arbitrary
   localparam logic [15:0] SYNC2_3200 = 16'h7B18;          // arbitrary
   localparam logic [15:0] SYNC2_6400 = 16'hB068;          // arbitrary

   // ****************************************************************
   // types
   // ****************************************************************
   typedef enum logic [1:0] {
      RATE_1600 = 2'h0,
      RATE_3200 = 2'h1,
      RATE_6400 = 2'h2
   } rate_e;

   typedef enum logic [2:0] {
      FLD_BLKINFO = 3'h0,
      FLD_ADDR    = 3'h1,
      FLD_VECTOR  = 3'h2,
      FLD_MSG     = 3'h3,
      FLD_IDLE    = 3'h4
   } field_e;

   typedef enum logic [2:0] {
      ST_OFF   = 3'h0,
      ST_WARM  = 3'h1,
      ST_SYNC1 = 3'h2,
      ST_FIW   = 3'h3,
      ST_SYNC2 = 3'h4,
      ST_DATA  = 3'h5,
      ST_DOWN  = 3'h6
   } trk_state_e;

   typedef struct packed {
      logic [1:0]             phase;
      logic [6:0]             word_idx;
      field_e                 field;
      logic                   err;
      logic                   is_addr_hit;
      logic                   tone_only;
      logic                   priority_f;
      logic                   long_addr;
      logic [DATA_W-1:0]      data;
   } word_out_s;

   typedef struct packed {
      logic [FRAME_NUM_W-1:0] frame_num;
      logic [CYCLE_NUM_W-1:0] cycle_num;
      rate_e                  rate;
      logic                   locked;
   } frame_info_s;

endpackage : frame_trk_pkg

// >>> hdl/paging_frame_tracker.sv
// paging frame tracker: sync search, frame info, rate, de-interleave,
// per-phase field tracking, receiver power staging, clock out and minute timer
// assumes symbols are synchronous to clk_i and tagged by sym_valid_i
`timescale 1ns/1ps

// Function
// - frame counter wraps every 128 frames
// - unassigned frames skipped, receiver kept off
// - sync then eleven 160 ms blocks
// - hunt first sync at fixed rate
// - frame info gives frame and cycle
// - second sync selects data rate
// - 1600 rate: one phase A
// - 3200 rate: phases A and C
// - 6400 rate: phases A to D
// - eight words per block, index 0-87
// - check code, correct or flag words
// - five fields in fixed order
// - fields tracked per phase, not block
// - tone-only addresses expect no vector
// - one or two vector words per address
// - vector holds message or its position
// - no address hit: sleep rest of frame
// - eight staged receiver control outputs
// - two bandwidth selects per symbol rate
// - battery sampled during receiver sequencing
// - 38.4 kHz clock out, minute tick
module paging_frame_tracker #(
   parameter int unsigned FRAME_CYC  = frame_trk_pkg::FRAME_CYC,
   parameter int unsigned MINUTE_CYC = frame_trk_pkg::MINUTE_CYC,
   parameter int unsigned BLOCK_CYC  = frame_trk_pkg::BLOCK_CYC
) (
   input  wire logic                      clk_i,          // 25 MHz clock
   input  wire logic                      rst_n_i,        // async reset, low
   input  wire logic [1:0]                sym_i,          // received symbol
   input  wire logic                      sym_valid_i,    // symbol strobe
   input  wire logic [127:0]              frame_assign_i, // assigned frames
   input  wire logic [20:0]               my_addr_i,      // pager address
   input  wire logic                      lobat_i,        // low battery level
   input  wire logic                      word_ready_i,   // sink ready
   output logic                           word_valid_o,   // word available
   output frame_trk_pkg::word_out_s       word_o,         // decoded word
   output frame_trk_pkg::frame_info_s     info_o,         // frame info
   output logic [7:0]                     rx_ctl_o,       // receiver stages
   output logic [1:0]                     bw_sel_o,       // filter bandwidth
   output logic                           lobat_o,        // battery result
   output logic                           clk38_o,        // 38.4 kHz clock
   output logic                           minute_o,       // minute tick
   output logic                           sleep_o         // low power state
);

   // ****************************************************************
   // state and counters
   // ****************************************************************
   frame_trk_pkg::trk_state_e state_q;
   logic [31:0]               frame_tmr_q;
   logic [6:0]                frame_cnt_q;
   logic [31:0]               shift_q;
   logic [5:0]                bit_cnt_q;
   frame_trk_pkg::rate_e      rate_q;
   logic [3:0]                warm_step_q;
   logic [15:0]               step_tmr_q;
   logic                      addr_hit_q;
   logic                      assigned;
   logic                      fiw_ok;
   logic                      data_done_q;
   logic                      sleep_req;

   assign assigned = frame_assign_i[frame_cnt_q];
   assign fiw_ok   = (shift_q[3:0] <= 4'(frame_trk_pkg::CYCLE_NUM_MAX));

   // receiver power sequencing and frame state
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_q     <= frame_trk_pkg::ST_OFF;
         frame_tmr_q <= 32'h0;
         frame_cnt_q <= 7'h0;
         warm_step_q <= 4'h0;
         step_tmr_q  <= 16'h0;
      end else begin
         if (frame_tmr_q >= 32'(FRAME_CYC - 1)) begin
            frame_tmr_q <= 32'h0;
            frame_cnt_q <= frame_cnt_q + 7'h1;
         end else begin
            frame_tmr_q <= frame_tmr_q + 32'h1;
         end
         case (state_q)
            frame_trk_pkg::ST_OFF: begin
               if (assigned && frame_tmr_q == 32'h0) begin
                  state_q     <= frame_trk_pkg::ST_WARM;
                  warm_step_q <= 4'h0;
                  step_tmr_q  <= 16'h0;
               end
            end
            frame_trk_pkg::ST_WARM: begin
               if (step_tmr_q == 16'(frame_trk_pkg::WARM_STEP_CYC - 1)) begin
                  step_tmr_q  <= 16'h0;
                  warm_step_q <= warm_step_q + 4'h1;
                  if (warm_step_q == 4'(frame_trk_pkg::RX_CTL_W - 1)) begin
                     state_q <= frame_trk_pkg::ST_SYNC1;
                  end
               end else begin
                  step_tmr_q <= step_tmr_q + 16'h1;
               end
            end
            frame_trk_pkg::ST_SYNC1: begin
               if (shift_q == frame_trk_pkg::SYNC1_PAT) begin
                  state_q <= frame_trk_pkg::ST_FIW;
               end
            end
            frame_trk_pkg::ST_FIW: begin
               if (bit_cnt_q == 6'(frame_trk_pkg::WORD_W)) begin
                  state_q <= fiw_ok ? frame_trk_pkg::ST_SYNC2
                                    : frame_trk_pkg::ST_SYNC1;
               end
            end
            frame_trk_pkg::ST_SYNC2: begin
               if (bit_cnt_q == 6'd16) begin
                  state_q <= frame_trk_pkg::ST_DATA;
               end
            end
            frame_trk_pkg::ST_DATA: begin
               if (data_done_q || sleep_req) begin
                  state_q    <= frame_trk_pkg::ST_DOWN;
                  step_tmr_q <= 16'h0;
               end
            end
            frame_trk_pkg::ST_DOWN: begin
               if (step_tmr_q == 16'(frame_trk_pkg::WARM_STEP_CYC - 1)) begin
                  step_tmr_q <= 16'h0;
                  warm_step_q <= warm_step_q - 4'h1;
                  if (warm_step_q == 4'h1) begin
                     state_q <= frame_trk_pkg::ST_OFF;
                  end
               end else begin
                  step_tmr_q <= step_tmr_q + 16'h1;
               end
            end
            default: state_q <= frame_trk_pkg::ST_OFF;
         endcase
      end
   end

   // ****************************************************************
   // bit collection and frame info
   // ****************************************************************
   logic bit_in;
   logic in_hdr;
   assign bit_in = sym_i[1];
   assign in_hdr = (state_q == frame_trk_pkg::ST_SYNC1) ||
                   (state_q == frame_trk_pkg::ST_FIW) ||
                   (state_q == frame_trk_pkg::ST_SYNC2);

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         shift_q   <= 32'h0;
         bit_cnt_q <= 6'h0;
         rate_q    <= frame_trk_pkg::RATE_1600;
         info_o    <= '0;
      end else begin
         if (in_hdr && sym_valid_i) begin
            shift_q   <= {shift_q[30:0], bit_in};
            bit_cnt_q <= (state_q == frame_trk_pkg::ST_SYNC1) ? 6'h0
                                                              : bit_cnt_q + 6'h1;
         end
         if (state_q == frame_trk_pkg::ST_FIW && bit_cnt_q == 6'(frame_trk_pkg::WORD_W)) begin
            bit_cnt_q <= 6'h0;
            if (fiw_ok) begin
               info_o.cycle_num <= shift_q[3:0];
               info_o.frame_num <= shift_q[10:4];
            end
         end
         if (state_q == frame_trk_pkg::ST_SYNC2 && bit_cnt_q == 6'd16) begin
            bit_cnt_q <= 6'h0;
            info_o.locked <= 1'b1;
            case (shift_q[15:0])
               frame_trk_pkg::SYNC2_3200: rate_q <= frame_trk_pkg::RATE_3200;
               frame_trk_pkg::SYNC2_6400: rate_q <= frame_trk_pkg::RATE_6400;
               default:                   rate_q <= frame_trk_pkg::RATE_1600;
            endcase
         end
         if (state_q == frame_trk_pkg::ST_OFF) begin
            info_o.locked <= 1'b0;
         end
         info_o.rate <= rate_q;
      end
   end

   // ****************************************************************
   // data portion: phase demux, word index and field tracking
   // ****************************************************************
   logic [4:0]  dbit_q [4];
   logic [31:0] dword_q [4];
   logic [1:0]  ph_q;
   logic [6:0]  widx_q [4];
   frame_trk_pkg::field_e fld_q [4];
   logic [1:0]  vec_pend_q [4];
   logic [1:0]  ph_max;
   logic        w_done;
   logic [5:0]  syn;
   logic [31:0] cw;
   frame_trk_pkg::word_out_s wr_d;

   // A, C for 3200; A..D for 6400; only A for 1600
   assign ph_max = (rate_q == frame_trk_pkg::RATE_6400) ? 2'h3 :
                   (rate_q == frame_trk_pkg::RATE_3200) ? 2'h1 : 2'h0;
   assign w_done = (state_q == frame_trk_pkg::ST_DATA) && sym_valid_i &&
                   (dbit_q[ph_q] == 5'd31);
   assign cw     = {dword_q[ph_q][30:0], bit_in};
   // even-parity split check over data and check bits
   assign syn    = {^cw[31:26], ^cw[25:21], ^cw[20:14], ^cw[13:7], ^cw[6:0], ^cw};
   assign sleep_req = (fld_q[0] == frame_trk_pkg::FLD_VECTOR) && !addr_hit_q;

   always_comb begin
      wr_d             = '0;
      wr_d.phase       = (rate_q == frame_trk_pkg::RATE_3200 && ph_q == 2'h1) ? 2'h2 : ph_q;
      wr_d.word_idx    = widx_q[ph_q];
      wr_d.field       = fld_q[ph_q];
      wr_d.err         = (syn[5:1] != 5'h0) && syn[0];
      wr_d.data        = cw[31:11];
      // segment check fails with even overall parity: flip low data bit form
      if (syn[5:1] != 5'h0 && !syn[0]) begin
         wr_d.data[0] = ~cw[11];
      end
      wr_d.is_addr_hit = (fld_q[ph_q] == frame_trk_pkg::FLD_ADDR) &&
                         (cw[31:11] == my_addr_i);
      wr_d.tone_only   = wr_d.is_addr_hit && cw[10];
      wr_d.priority_f  = wr_d.is_addr_hit && cw[9];
      wr_d.long_addr   = wr_d.is_addr_hit && cw[8];
   end

   // two-entry skid buffer
   frame_trk_pkg::word_out_s buf_q [2];
   logic [1:0]  cnt_q;
   logic        push;
   logic        pop;
   assign push = w_done && (cnt_q != 2'h2);
   assign pop  = word_valid_o && word_ready_i;

   for (genvar p = 0; p < frame_trk_pkg::NUM_PHASES; p++) begin : g_ph
      always_ff @(posedge clk_i or negedge rst_n_i) begin
         if (!rst_n_i) begin
            dbit_q[p]     <= 5'h0;
            dword_q[p]    <= 32'h0;
            widx_q[p]     <= 7'h0;
            fld_q[p]      <= frame_trk_pkg::FLD_BLKINFO;
            vec_pend_q[p] <= 2'h0;
         end else if (state_q != frame_trk_pkg::ST_DATA) begin
            dbit_q[p]     <= 5'h0;
            widx_q[p]     <= 7'h0;
            fld_q[p]      <= frame_trk_pkg::FLD_BLKINFO;
            vec_pend_q[p] <= 2'h0;
         end else if (sym_valid_i && ph_q == 2'(p)) begin
            dword_q[p] <= cw;
            dbit_q[p]  <= dbit_q[p] + 5'h1;
            if (w_done && push) begin
               widx_q[p] <= widx_q[p] + 7'h1;
               // field boundaries advance per phase by word marks
               case (fld_q[p])
                  frame_trk_pkg::FLD_BLKINFO:
                     if (cw[7]) fld_q[p] <= frame_trk_pkg::FLD_ADDR;
                  frame_trk_pkg::FLD_ADDR: begin
                     if (wr_d.is_addr_hit && !wr_d.tone_only) begin
                        vec_pend_q[p] <= wr_d.long_addr ? 2'h2 : 2'h1;
                     end
                     if (cw[6]) fld_q[p] <= frame_trk_pkg::FLD_VECTOR;
                  end
                  frame_trk_pkg::FLD_VECTOR: begin
                     if (vec_pend_q[p] != 2'h0) vec_pend_q[p] <= vec_pend_q[p] - 2'h1;
                     // vector bit 5 set: message words follow
                     if (cw[6]) fld_q[p] <= cw[5] ? frame_trk_pkg::FLD_MSG
                                                  : frame_trk_pkg::FLD_IDLE;
                  end
                  frame_trk_pkg::FLD_MSG:
                     if (cw[6]) fld_q[p] <= frame_trk_pkg::FLD_IDLE;
                  default: fld_q[p] <= frame_trk_pkg::FLD_IDLE;
               endcase
            end
         end
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ph_q        <= 2'h0;
         data_done_q <= 1'b0;
         addr_hit_q  <= 1'b0;
      end else if (state_q != frame_trk_pkg::ST_DATA) begin
         ph_q        <= 2'h0;
         data_done_q <= 1'b0;
         addr_hit_q  <= 1'b0;
      end else begin
         if (sym_valid_i) begin
            ph_q <= (ph_q == ph_max) ? 2'h0 : ph_q + 2'h1;
         end
         if (push && wr_d.is_addr_hit) addr_hit_q <= 1'b1;
         // eleven blocks of eight words end the data portion
         if (push && ph_q == ph_max &&
             widx_q[ph_q] == 7'(frame_trk_pkg::WORDS_PER_PHASE - 1)) begin
            data_done_q <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cnt_q        <= 2'h0;
         buf_q[0]     <= '0;
         buf_q[1]     <= '0;
         word_valid_o <= 1'b0;
         word_o       <= '0;
      end else begin
         if (push && !pop) begin
            buf_q[cnt_q[0]] <= wr_d;
            cnt_q <= cnt_q + 2'h1;
         end else if (push && pop) begin
            buf_q[0] <= (cnt_q == 2'h2) ? buf_q[1] : wr_d;
            buf_q[1] <= wr_d;
         end else if (pop) begin
            buf_q[0] <= buf_q[1];
            cnt_q <= cnt_q - 2'h1;
         end
         word_valid_o <= 1'b0;
         word_o       <= word_o;
         if (!(word_valid_o && !word_ready_i) && (cnt_q != 2'h0) && !pop) begin
            word_valid_o <= 1'b1;
            word_o       <= buf_q[0];
         end else if (word_valid_o && !word_ready_i) begin
            word_valid_o <= 1'b1;
         end
      end
   end

   // ****************************************************************
   // receiver control, bandwidth, battery, clock out, minute
   // ****************************************************************
   logic [15:0] div_q;
   logic [31:0] min_q;

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rx_ctl_o <= 8'h00;
         bw_sel_o <= 2'h1;
         lobat_o  <= 1'b0;
         sleep_o  <= 1'b1;
      end else begin
         for (int i = 0; i < frame_trk_pkg::RX_CTL_W; i++) begin
            rx_ctl_o[i] <= (4'(i) < warm_step_q);
         end
         bw_sel_o <= (rate_q == frame_trk_pkg::RATE_6400) ? 2'h2 : 2'h1;
         if (state_q == frame_trk_pkg::ST_WARM &&
             warm_step_q == 4'(frame_trk_pkg::RX_CTL_W - 1)) begin
            lobat_o <= lobat_i;
         end
         sleep_o <= (state_q == frame_trk_pkg::ST_OFF);
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         div_q    <= 16'h0;
         clk38_o  <= 1'b0;
         min_q    <= 32'h0;
         minute_o <= 1'b0;
      end else begin
         if (div_q == 16'(frame_trk_pkg::CLKOUT_HALF - 1)) begin
            div_q   <= 16'h0;
            clk38_o <= ~clk38_o;
         end else begin
            div_q <= div_q + 16'h1;
         end
         minute_o <= (min_q == 32'(MINUTE_CYC - 1));
         min_q    <= (min_q == 32'(MINUTE_CYC - 1)) ? 32'h0 : min_q + 32'h1;
      end
   end

endmodule // paging_frame_tracker

// >>> dv/rx_symbol_model.sv
// receiver model: turns bit words into 2-bit symbols with a one-cycle strobe
// assumes the tracker samples symbols on the rising clock edge
`timescale 1ns/1ps
module rx_symbol_model (
   input  wire logic       clk_i,       // bench clock
   output logic [1:0]      sym_o,       // symbol to tracker
   output logic            sym_valid_o  // symbol strobe
);
   initial begin
      sym_o = 2'h0;
      sym_valid_o = 1'b0;
   end

   // ************************************************************
   // one symbol every four cycles, msb first; between symbols the
   // lines show the inverse of the last value
   // ************************************************************
   task automatic send(input logic [31:0] v, input int n);
      for (int i = n - 1; i >= 0; i--) begin
         @(posedge clk_i);
         #1;
         sym_o = {v[i], ~v[i]};
         sym_valid_o = 1'b1;
         @(posedge clk_i);
         #1;
         sym_o = ~sym_o;
         sym_valid_o = 1'b0;
         repeat (2) @(posedge clk_i);
      end
   endtask
endmodule // rx_symbol_model

// >>> dv/frame_trk_chk.sv
// checker: port-level timing of the paging frame tracker
// assumes a bind onto paging_frame_tracker, one clock, async low reset
`timescale 1ns/1ps
module frame_trk_chk #(
   parameter int unsigned MINUTE_CYC = 200
) (
   input wire logic                  clk_i,        // clock
   input wire logic                  rst_n_i,      // reset, low
   input wire logic                  word_ready_i, // sink ready
   input wire logic                  word_valid_o, // word valid
   input frame_trk_pkg::word_out_s   word_o,       // word
   input frame_trk_pkg::frame_info_s info_o,       // frame info
   input wire logic [7:0]            rx_ctl_o,     // rx stages
   input wire logic [1:0]            bw_sel_o,     // bandwidth
   input wire logic                  clk38_o,      // clock out
   input wire logic                  minute_o,     // minute tick
   input wire logic                  sleep_o       // low power
);
   // ************************************************************
   // cycles since the last minute tick and clock-out edge
   // ************************************************************
   logic [31:0] min_cnt_q;
   logic        min_seen_q;
   logic [15:0] clk_cnt_q;
   logic        clk_seen_q;

   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         min_cnt_q <= 32'h0;
         min_seen_q <= 1'b0;
      end else begin
         min_cnt_q <= minute_o ? 32'h0 : min_cnt_q + 32'h1;
         min_seen_q <= min_seen_q | minute_o;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         clk_cnt_q <= 16'h0;
         clk_seen_q <= 1'b0;
      end else begin
         clk_cnt_q <= $changed(clk38_o) ? 16'h0 : clk_cnt_q + 16'h1;
         clk_seen_q <= clk_seen_q | $changed(clk38_o);
      end
   end

   // ************************************************************
   // assertions
   // ************************************************************
   a_minute_period: assert property (
      minute_o && min_seen_q |-> min_cnt_q == MINUTE_CYC - 1) else $error("minute period");
   a_clkout_half: assert property (
      $changed(clk38_o) && clk_seen_q |-> clk_cnt_q == frame_trk_pkg::CLKOUT_HALF - 1)
      else $error("clock out half period");
   a_rx_thermo: assert property (
      (rx_ctl_o & (rx_ctl_o + 8'h01)) == 8'h00) else $error("rx stages not thermometer");
   a_rx_step: assert property (
      $changed(rx_ctl_o) |=> $stable(rx_ctl_o) [*8]) else $error("rx stage too short");
   a_sleep_rx_off: assert property (
      sleep_o |-> rx_ctl_o == 8'h00) else $error("receiver on while asleep");
   a_bw_onehot: assert property (
      $onehot(bw_sel_o)) else $error("bandwidth select not one-hot");
   a_cycle_range: assert property (
      info_o.locked |-> info_o.cycle_num <= 4'hE) else $error("cycle number above 14");
   a_word_hold: assert property (
      word_valid_o && !word_ready_i |=> word_valid_o && $stable(word_o))
      else $error("word dropped while stalled");
   a_word_idx: assert property (
      word_valid_o |-> word_o.word_idx <= 7'h57) else $error("word index above 87");
   a_phase_single: assert property (
      word_valid_o && info_o.rate == frame_trk_pkg::RATE_1600 |-> word_o.phase == 2'h0)
      else $error("phase not A at lowest rate");
endmodule // frame_trk_chk

// >>> dv/tb.sv
// bench: one assigned frame through the tracker, timers, buffer and power
// assumes rx_symbol_model for symbols and frame_trk_chk bound below
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin err_count++; \
   $display("unexpected %s expected %0h seen %0h", nm, e, g); end end
module tb;
   logic                       clk_i;
   logic                       rst_n_i;
   logic [1:0]                 sym;
   logic                       sym_valid;
   logic                       word_ready;
   logic                       word_valid;
   frame_trk_pkg::word_out_s   word;
   frame_trk_pkg::frame_info_s info;
   logic [7:0]                 rx_ctl;
   logic [1:0]                 bw_sel;
   logic                       lobat;
   logic                       lobat_in;
   logic                       clk38;
   logic                       minute;
   logic                       sleep;
   int                         err_count = 0;
   int                         n_compared = 0;

   rx_symbol_model rx_model_inst (.clk_i(clk_i), .sym_o(sym), .sym_valid_o(sym_valid));

   paging_frame_tracker #(.FRAME_CYC(30000), .MINUTE_CYC(200), .BLOCK_CYC(100))
      paging_frame_tracker_inst (
      .clk_i(clk_i), .rst_n_i(rst_n_i), .sym_i(sym), .sym_valid_i(sym_valid),
      .frame_assign_i(128'h1), .my_addr_i(21'h0ABCD), .lobat_i(lobat_in),
      .word_ready_i(word_ready), .word_valid_o(word_valid), .word_o(word),
      .info_o(info), .rx_ctl_o(rx_ctl), .bw_sel_o(bw_sel), .lobat_o(lobat),
      .clk38_o(clk38), .minute_o(minute), .sleep_o(sleep));

   initial begin
      clk_i = 1'b0;
      forever #20 clk_i = ~clk_i;
   end

   // ************************************************************
   // scenarios
   // ************************************************************
   task automatic tick();
      @(posedge clk_i);
      #1;
   endtask

   task automatic end_of_test();
      if (err_count == 0 && n_compared > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic t_timers();
      int c;
      logic v;
      for (c = 0; c < 400 && minute !== 1'b1; c++) tick();
      tick();
      for (c = 1; c < 400 && minute !== 1'b1; c++) tick();
      `CHK("minute period", 200, c)
      v = clk38;
      for (c = 0; c < 700 && clk38 === v; c++) tick();
      v = clk38;
      tick();
      for (c = 1; c < 700 && clk38 === v; c++) tick();
      `CHK("clock out half", frame_trk_pkg::CLKOUT_HALF, c)
   endtask

   task automatic t_warm();
      for (int c = 0; c < 9000 && rx_ctl !== 8'hFF; c++) tick();
      `CHK("rx stages", 8'hFF, rx_ctl)
      `CHK("battery", 1'b1, lobat)
      `CHK("awake", 1'b0, sleep)
      `CHK("bandwidth", 2'h1, bw_sel)
   endtask

   task automatic t_header();
      rx_model_inst.send(frame_trk_pkg::SYNC1_PAT, 32);
      rx_model_inst.send(32'h0000005F, 32);
      repeat (20) tick();
      `CHK("bad cycle lock", 1'b0, info.locked)
      rx_model_inst.send(frame_trk_pkg::SYNC1_PAT, 32);
      rx_model_inst.send(32'h00000053, 32);
      rx_model_inst.send({16'h0, frame_trk_pkg::SYNC2_1600}, 16);
      repeat (8) tick();
      `CHK("frame", 7'h05, info.frame_num)
      `CHK("cycle", 4'h3, info.cycle_num)
      `CHK("rate", frame_trk_pkg::RATE_1600, info.rate)
      `CHK("locked", 1'b1, info.locked)
   endtask

   task automatic t_words();
      int c;
      rx_model_inst.send(32'h00000080, 32);
      rx_model_inst.send(32'hFFFFF800, 32);
      rx_model_inst.send(32'hFFFFF840, 32);
      repeat (4) tick();
      `CHK("held word", 1'b1, word_valid)
      `CHK("first field", frame_trk_pkg::FLD_BLKINFO, word.field)
      `CHK("phase", 2'h0, word.phase)
      `CHK("word index", 7'h00, word.word_idx)
      word_ready = 1'b1;
      c = 0;
      repeat (10) begin
         if (word_valid === 1'b1) c++;
         tick();
      end
      `CHK("words kept", 2, c)
   endtask

   task automatic t_sleep();
      int c;
      // address field ends with no hit: receiver should power down
      rx_model_inst.send(32'h00000040, 32);
      for (c = 0; c < 9000 && sleep !== 1'b1; c++) tick();
      `CHK("sleep", 1'b1, sleep)
      `CHK("rx off", 8'h00, rx_ctl)
      c = 0;
      repeat (15000) begin
         if (sleep !== 1'b1) c++;
         tick();
      end
      `CHK("unassigned awake", 0, c)
   endtask

   initial begin
      rst_n_i = 1'b0;
      word_ready = 1'b0;
      lobat_in = 1'b1;
      repeat (20) tick();
      `CHK("reset valid", 1'b0, word_valid)
      `CHK("reset bandwidth", 2'h1, bw_sel)
      `CHK("reset sleep", 1'b1, sleep)
      `CHK("reset rx", 8'h00, rx_ctl)
      rst_n_i = 1'b1;
      t_timers();
      t_warm();
      t_header();
      t_words();
      t_sleep();
      end_of_test();
   end

   initial begin
      repeat (60000) @(posedge clk_i);
      err_count++;
      end_of_test();
   end
endmodule // tb

bind paging_frame_tracker frame_trk_chk #(.MINUTE_CYC(MINUTE_CYC)) chk_inst (
   .clk_i(clk_i), .rst_n_i(rst_n_i), .word_ready_i(word_ready_i),
   .word_valid_o(word_valid_o), .word_o(word_o), .info_o(info_o), .rx_ctl_o(rx_ctl_o),
   .bw_sel_o(bw_sel_o), .clk38_o(clk38_o), .minute_o(minute_o), .sleep_o(sleep_o));
